// File: oeb_defs.svh
// constants for the receive endpoint buffer block and its cpu controller
`ifndef OEB_DEFS_SVH
`define OEB_DEFS_SVH
// ==========================================================================
// sizes
`define OEB_NUM_EP      4
`define OEB_EP_W        2
`define OEB_BUF_BYTES   64
`define OEB_AXI_AW      8
// ==========================================================================
// status flag codes {hi, lo}
`define OEB_FLAGS_EMPTY 2'h0
`define OEB_FLAGS_ONE_D 2'h2
`define OEB_FLAGS_FULL  2'h3
// ==========================================================================
// controller register byte offsets
`define OEB_REG_CFG     8'h00
`define OEB_REG_CMD     8'h04
`define OEB_REG_RDREQ   8'h08
`define OEB_REG_DATA    8'h0C
`define OEB_REG_STATUS  8'h10
// ==========================================================================
// field positions
`define OEB_CFG_DBL     0
`define OEB_CFG_CONT    4
`define OEB_CFG_AUTO    8
`define OEB_CFG_RFB     12
`define OEB_CMD_REL     0
`define OEB_CMD_FLUSH   4
`define OEB_RQ_WORD     0
`define OEB_RQ_EP       1
`define OEB_RQ_ODD      3
`define OEB_DATA_VALID  16
`define OEB_ST_LO       4
`define OEB_ST_TOG      8
// ==========================================================================
// reset values and responses
`define OEB_CFG_RESET   16'h0000
`define OEB_RESP_OKAY   2'h0
`define OEB_RESP_SLVERR 2'h2
`endif

// File: oeb_pkg.sv
// types shared by the receive endpoint buffer block and its controller
package oeb_pkg;
   typedef enum logic [0:0] {
      OEB_W_IDLE = 1'b0,
      OEB_W_RESP = 1'b1
   } oeb_wst_t;
   typedef logic [1:0] oeb_flags_t;
endpackage

// File: oeb_if.sv
// link between the endpoint buffer logic and its cpu-side controller
`timescale 1ns/1ps
`include "oeb_defs.svh"
interface oeb_if;
   logic [`OEB_NUM_EP-1:0] cfgDouble;
   logic [`OEB_NUM_EP-1:0] cfgContinuous;
   logic [`OEB_NUM_EP-1:0] automaticRelease;
   logic [`OEB_NUM_EP-1:0] rateFeedbackEnable;
   logic [`OEB_NUM_EP-1:0] rxReleaseStrobe;
   logic [`OEB_NUM_EP-1:0] rxFlushStrobe;
   logic                   rdReq;
   logic [`OEB_EP_W-1:0]   rdEp;
   logic                   rdWord;
   logic [`OEB_NUM_EP-1:0] rxStatusFlagHi;
   logic [`OEB_NUM_EP-1:0] rxStatusFlagLo;
   logic [`OEB_NUM_EP-1:0] inToggle;
   logic [15:0]            rdData;
   logic                   rdAck;
   modport dev (
      input  cfgDouble, cfgContinuous, automaticRelease, rateFeedbackEnable,
      input  rxReleaseStrobe, rxFlushStrobe, rdReq, rdEp, rdWord,
      output rxStatusFlagHi, rxStatusFlagLo, inToggle, rdData, rdAck
   );
   modport ctrl (
      output cfgDouble, cfgContinuous, automaticRelease, rateFeedbackEnable,
      output rxReleaseStrobe, rxFlushStrobe, rdReq, rdEp, rdWord,
      input  rxStatusFlagHi, rxStatusFlagLo, inToggle, rdData, rdAck
   );
endinterface

// File: oeb_rx_dev.sv
// receive endpoint buffer status logic with rate-feedback in-endpoint toggles
// ==========================================================================
// Operation
// - continuous single: full set or short completes
// - release strobe empties single buffer 11 to 00
// - double receive: 00 to 10 to 11
// - double release: 11 to 10 to 00
// - non-continuous: every good packet completes
// - auto release single clears after full readout
// - auto release double releases per set read
// - flush acts as one set release
// - software flushes only while upper flag set
// - flags 00 empty, 10 one, 11 full
// - interrupt transfers handled just like bulk
// - rate feedback flips toggle every sent packet
// - rate feedback setup order done by software
// - rate feedback endpoint never answers nak
// - writing inactive value to strobe bits ignored
// - control bits accept byte or word, any address; only the exact aligned register offset is written here
// - fifo reads only at even addresses
// - software reset keeps all register contents
// - fifo read advances pointer two or one
// - cpu reads fifo only while upper flag set
`timescale 1ns/1ps
`include "oeb_defs.svh"
module oeb_rx_dev
   import oeb_pkg::*;
#(
   parameter int BUF_BYTES = `OEB_BUF_BYTES
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   oeb_if.dev                          cpu,
   input  wire logic                   rxValid,
   input  wire logic [7:0]             rxByte,
   input  wire logic [`OEB_EP_W-1:0]   rxEp,
   input  wire logic                   rxPktEnd,
   input  wire logic                   rxShort,
   input  wire logic [`OEB_EP_W-1:0]   txEp,
   input  wire logic                   txDone,
   input  wire logic                   txAck,
   input  wire logic [`OEB_NUM_EP-1:0] inBufReady,
   output      logic [`OEB_NUM_EP-1:0] inNak,
   output      logic [`OEB_NUM_EP-1:0] rxOverrun
);
   localparam int PW = $clog2(BUF_BYTES);

   // ==========================================================================
   // shared state
   logic [15:0]            epData [0:`OEB_NUM_EP-1];
   logic [15:0]            rdData_ff;
   logic                   rdAck_ff;
   logic [`OEB_NUM_EP-1:0] inNak_ff;
   logic [`OEB_NUM_EP-1:0] inToggle_ff;
   logic [`OEB_NUM_EP-1:0] rxOverrun_ff;
   oeb_flags_t             flags [0:`OEB_NUM_EP-1];

   // status decode kept in one place so both flag outputs agree
   function automatic oeb_flags_t flagCode(input logic [1:0] held, input logic dbl);
      oeb_flags_t f;
      f = `OEB_FLAGS_EMPTY;
      if (held == 2'h2) begin
         f = `OEB_FLAGS_FULL;
      end else if (held == 2'h1) begin
         f = dbl ? `OEB_FLAGS_ONE_D : `OEB_FLAGS_FULL;
      end
      return f;
   endfunction

   // ==========================================================================
   // one buffer per endpoint
   genvar e;
   generate
      for (e = 0; e < `OEB_NUM_EP; e++) begin : g_ep
         localparam logic [`OEB_EP_W-1:0] EPID = `OEB_EP_W'(e);
         logic [7:0]  mem [0:2*BUF_BYTES-1];
         logic [1:0]  held_ff;
         logic        wrSet_ff;
         logic        rdSet_ff;
         logic [PW:0] wrCnt_ff;
         logic [PW:0] rdPtr_ff;
         logic [PW:0] len_ff [0:1];
         logic [1:0]  cap;
         logic        spaceOk;
         logic        byteOk;
         logic        setDone;
         logic        rdHit;
         logic        autoDone;
         logic        relNow;
         logic [PW:0] nxt_rdPtr;
         logic [PW-1:0] ptrNext;

         always_comb begin
            cap       = cpu.cfgDouble[e] ? 2'h2 : 2'h1;
            spaceOk   = held_ff != cap;
            byteOk    = rxValid && rxEp == EPID && spaceOk
                        && wrCnt_ff != (PW+1)'(BUF_BYTES);
            // interrupt transfers use the very same path as bulk
            setDone   = rxPktEnd && rxEp == EPID && spaceOk
                        && (!cpu.cfgContinuous[e] || rxShort
                            || wrCnt_ff == (PW+1)'(BUF_BYTES));
            // odd-address reads never arrive, the controller screens them
            rdHit     = cpu.rdReq && cpu.rdEp == EPID && held_ff != 2'h0;
            nxt_rdPtr = rdPtr_ff + (cpu.rdWord ? (PW+1)'(2) : (PW+1)'(1));
            autoDone  = rdHit && cpu.automaticRelease[e]
                        && nxt_rdPtr >= len_ff[rdSet_ff];
            // flush is just another release source
            relNow    = held_ff != 2'h0 && (cpu.rxReleaseStrobe[e]
                        || cpu.rxFlushStrobe[e] || autoDone);
            ptrNext   = rdPtr_ff[PW-1:0] + 1'b1;
         end

         // receive side
         always_ff @(posedge clk_sys) begin
            if (byteOk) begin
               mem[{wrSet_ff, wrCnt_ff[PW-1:0]}] <= rxByte;
            end
         end

         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               wrCnt_ff  <= '0;
               wrSet_ff  <= 1'b0;
               len_ff[0] <= '0;
               len_ff[1] <= '0;
            end else if (setDone) begin
               wrCnt_ff        <= '0;
               len_ff[wrSet_ff] <= wrCnt_ff;
               wrSet_ff        <= cpu.cfgDouble[e] ? ~wrSet_ff : 1'b0;
            end else if (byteOk) begin
               wrCnt_ff <= wrCnt_ff + 1'b1;
            end
         end

         // set count, +1 on completion, -1 on release, both may coincide
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               held_ff <= 2'h0;
            end else begin
               held_ff <= held_ff + {1'b0, setDone} - {1'b0, relNow};
            end
         end

         // cpu read side
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               rdPtr_ff <= '0;
               rdSet_ff <= 1'b0;
            end else if (relNow) begin
               rdPtr_ff <= '0;
               rdSet_ff <= cpu.cfgDouble[e] ? ~rdSet_ff : 1'b0;
            end else if (rdHit) begin
               rdPtr_ff <= nxt_rdPtr;
            end
         end

         // little-endian word, high byte zero on byte reads
         assign epData[e] = {cpu.rdWord ? mem[{rdSet_ff, ptrNext}] : 8'h00,
                             mem[{rdSet_ff, rdPtr_ff[PW-1:0]}]};
         assign flags[e]  = flagCode(held_ff, cpu.cfgDouble[e]);
         assign cpu.rxStatusFlagHi[e] = flags[e][1];
         assign cpu.rxStatusFlagLo[e] = flags[e][0];

         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               rxOverrun_ff[e] <= 1'b0;
            end else begin
               rxOverrun_ff[e] <= rxValid && rxEp == EPID && !byteOk;
            end
         end

         // ==========================================================================
         // in-endpoint toggle and nak
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               inToggle_ff[e] <= 1'b0;
               inNak_ff[e]    <= 1'b1;
            end else begin
               // feedback data needs no handshake to move on
               if (txDone && txEp == EPID && (txAck || cpu.rateFeedbackEnable[e])) begin
                  inToggle_ff[e] <= ~inToggle_ff[e];
               end
               inNak_ff[e] <= !cpu.rateFeedbackEnable[e] && !inBufReady[e];
            end
         end
      end
   endgenerate

   // ==========================================================================
   // read data return, one cycle after the request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdData_ff <= 16'h0000;
         rdAck_ff  <= 1'b0;
      end else begin
         rdAck_ff <= cpu.rdReq;
         if (cpu.rdReq) begin
            rdData_ff <= epData[cpu.rdEp];
         end
      end
   end

   // only the hard reset clears state; no soft reset path exists
   assign cpu.rdData   = rdData_ff;
   assign cpu.rdAck    = rdAck_ff;
   assign cpu.inToggle = inToggle_ff;
   assign inNak        = inNak_ff;
   assign rxOverrun    = rxOverrun_ff;
endmodule

// File: oeb_cpu_ctrl.sv
// axi4-lite controller that drives the endpoint buffer link for software
`timescale 1ns/1ps
`include "oeb_defs.svh"
module oeb_cpu_ctrl
   import oeb_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   oeb_if.ctrl                        dev,
   input  wire logic [`OEB_AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [`OEB_AXI_AW-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready
);
   // ==========================================================================
   // state
   oeb_wst_t               wst_ff;
   logic                   awHeld_ff, wHeld_ff, awready_ff, wready_ff;
   logic [`OEB_AXI_AW-1:0] awaddr_ff;
   logic [31:0]            wdata_ff;
   logic [3:0]             wstrb_ff;
   logic                   bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]             bresp_ff, rresp_ff;
   logic [31:0]            rdata_ff;
   logic [15:0]            cfg_ff, devData_ff;
   logic                   dataValid_ff, rdReq_ff, rdWord_ff;
   logic [`OEB_EP_W-1:0]   rdEp_ff;
   logic [`OEB_NUM_EP-1:0] relStb_ff, flushStb_ff;
   logic                   commit, wrCmd, wrReq, rdDataReg;
   logic [`OEB_EP_W-1:0]   reqEp;

   function automatic logic isMapped(input logic [`OEB_AXI_AW-1:0] a);
      return a[1:0] == 2'h0 && (a == `OEB_REG_CFG || a == `OEB_REG_CMD
             || a == `OEB_REG_RDREQ || a == `OEB_REG_DATA || a == `OEB_REG_STATUS);
   endfunction

   always_comb begin
      commit    = wst_ff == OEB_W_IDLE && awHeld_ff && wHeld_ff;
      wrCmd     = commit && awaddr_ff == `OEB_REG_CMD && wstrb_ff[0];
      wrReq     = commit && awaddr_ff == `OEB_REG_RDREQ && wstrb_ff[0];
      rdDataReg = s_axi_arvalid && arready_ff && s_axi_araddr == `OEB_REG_DATA;
      reqEp     = wdata_ff[`OEB_RQ_EP +: `OEB_EP_W];
   end

   // ==========================================================================
   // write channel, address and data in either order
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wst_ff     <= OEB_W_IDLE;
         awHeld_ff  <= 1'b0;
         wHeld_ff   <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= 32'h00000000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `OEB_RESP_OKAY;
      end else begin
         case (wst_ff)
            OEB_W_IDLE: begin
               awready_ff <= !awHeld_ff && !(s_axi_awvalid && awready_ff);
               wready_ff  <= !wHeld_ff && !(s_axi_wvalid && wready_ff);
               if (s_axi_awvalid && awready_ff) begin
                  awHeld_ff <= 1'b1;
                  awaddr_ff <= s_axi_awaddr;
               end
               if (s_axi_wvalid && wready_ff) begin
                  wHeld_ff <= 1'b1;
                  wdata_ff <= s_axi_wdata;
                  wstrb_ff <= s_axi_wstrb;
               end
               if (commit) begin
                  awHeld_ff  <= 1'b0;
                  wHeld_ff   <= 1'b0;
                  awready_ff <= 1'b0;
                  wready_ff  <= 1'b0;
                  bvalid_ff  <= 1'b1;
                  bresp_ff   <= isMapped(awaddr_ff) ? `OEB_RESP_OKAY : `OEB_RESP_SLVERR;
                  wst_ff     <= OEB_W_RESP;
               end
            end
            OEB_W_RESP: begin
               if (s_axi_bready) begin
                  bvalid_ff <= 1'b0;
                  wst_ff    <= OEB_W_IDLE;
               end
            end
            default: begin
               wst_ff <= OEB_W_IDLE;
            end
         endcase
      end
   end

   // configuration, byte lanes honoured so either byte may be written alone
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_ff <= `OEB_CFG_RESET;
      end else if (commit && awaddr_ff == `OEB_REG_CFG) begin
         if (wstrb_ff[0]) cfg_ff[7:0] <= wdata_ff[7:0];
         if (wstrb_ff[1]) cfg_ff[15:8] <= wdata_ff[15:8];
      end
   end

   // one-cycle strobes; a zero bit simply raises nothing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         relStb_ff   <= '0;
         flushStb_ff <= '0;
         rdReq_ff    <= 1'b0;
         rdEp_ff     <= '0;
         rdWord_ff   <= 1'b0;
      end else begin
         relStb_ff   <= wrCmd ? wdata_ff[`OEB_CMD_REL +: `OEB_NUM_EP] : '0;
         // flush bits of endpoints with the upper flag clear are screened out here
         flushStb_ff <= wrCmd ? wdata_ff[`OEB_CMD_FLUSH +: `OEB_NUM_EP]
                               & dev.rxStatusFlagHi : '0;
         // odd address or empty endpoint: request dropped, no data update
         rdReq_ff    <= wrReq && !wdata_ff[`OEB_RQ_ODD] && dev.rxStatusFlagHi[reqEp];
         if (wrReq) begin
            rdEp_ff   <= reqEp;
            rdWord_ff <= wdata_ff[`OEB_RQ_WORD];
         end
      end
   end

   // returned fifo data; a fresh answer beats a clearing read
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         devData_ff   <= 16'h0000;
         dataValid_ff <= 1'b0;
      end else if (dev.rdAck) begin
         devData_ff   <= dev.rdData;
         dataValid_ff <= 1'b1;
      end else if (rdDataReg) begin
         dataValid_ff <= 1'b0;
      end
   end

   // ==========================================================================
   // read channel
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= `OEB_RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= isMapped(s_axi_araddr) ? `OEB_RESP_OKAY : `OEB_RESP_SLVERR;
         case (s_axi_araddr)
            `OEB_REG_CFG:    rdata_ff <= {16'h0000, cfg_ff};
            `OEB_REG_DATA:   rdata_ff <= {15'h0000, dataValid_ff, devData_ff};
            `OEB_REG_STATUS: rdata_ff <= {20'h00000, dev.inToggle,
                                          dev.rxStatusFlagLo, dev.rxStatusFlagHi};
            default:         rdata_ff <= 32'h00000000;
         endcase
      end else if (rvalid_ff) begin
         if (s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
         end
      end else begin
         arready_ff <= 1'b1;
      end
   end

   assign dev.cfgDouble          = cfg_ff[`OEB_CFG_DBL +: `OEB_NUM_EP];
   assign dev.cfgContinuous      = cfg_ff[`OEB_CFG_CONT +: `OEB_NUM_EP];
   assign dev.automaticRelease   = cfg_ff[`OEB_CFG_AUTO +: `OEB_NUM_EP];
   assign dev.rateFeedbackEnable = cfg_ff[`OEB_CFG_RFB +: `OEB_NUM_EP];
   assign dev.rxReleaseStrobe    = relStb_ff;
   assign dev.rxFlushStrobe      = flushStb_ff;
   assign dev.rdReq              = rdReq_ff;
   assign dev.rdEp               = rdEp_ff;
   assign dev.rdWord             = rdWord_ff;
   assign s_axi_awready          = awready_ff;
   assign s_axi_wready           = wready_ff;
   assign s_axi_bvalid           = bvalid_ff;
   assign s_axi_bresp            = bresp_ff;
   assign s_axi_arready          = arready_ff;
   assign s_axi_rvalid           = rvalid_ff;
   assign s_axi_rdata            = rdata_ff;
   assign s_axi_rresp            = rresp_ff;
endmodule

// File: oeb_link_properties.sv
// concurrent checks on the endpoint buffer link between device and controller
`timescale 1ns/1ps
`include "oeb_defs.svh"
module oeb_link_properties
   import oeb_pkg::*;
(
   input wire logic                   clk_sys,
   input wire logic                   rst,
   input wire logic [`OEB_NUM_EP-1:0] cfgDouble,
   input wire logic [`OEB_NUM_EP-1:0] rxReleaseStrobe,
   input wire logic [`OEB_NUM_EP-1:0] rxFlushStrobe,
   input wire logic                   rdReq,
   input wire logic [`OEB_NUM_EP-1:0] rxStatusFlagHi,
   input wire logic [`OEB_NUM_EP-1:0] rxStatusFlagLo,
   input wire logic                   rdAck
);
   // ==========================================================================
   // flag and strobe relations
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_FLAG_CODE: assert property ((~rxStatusFlagHi & rxStatusFlagLo) == 4'h0)
      else $error("flag code 01 seen");
   AST_SINGLE_PAIR: assert property (((rxStatusFlagHi ^ rxStatusFlagLo) & ~cfgDouble) == 4'h0)
      else $error("single buffer flags split");
   AST_READ_ACK: assert property (rdReq |=> rdAck)
      else $error("fifo read not acknowledged");
   AST_NO_STRAY_ACK: assert property (!rdReq |=> !rdAck)
      else $error("ack without read");
   AST_FLUSH_GATED: assert property ((rxFlushStrobe & ~rxStatusFlagHi) == 4'h0)
      else $error("flush on empty endpoint");
   AST_REL_PULSE: assert property (rxReleaseStrobe != 4'h0 |=> rxReleaseStrobe == 4'h0)
      else $error("release strobe longer than one cycle");
   AST_DROP_CAUSE: assert property ((($past(rxStatusFlagHi) & ~rxStatusFlagHi) != 4'h0)
      |-> ($past(rxReleaseStrobe | rxFlushStrobe) != 4'h0 || rdAck))
      else $error("flags emptied without release");
   AST_DBL_KEEP: assert property ((($past(rxReleaseStrobe | rxFlushStrobe)
      & $past(cfgDouble & rxStatusFlagHi & rxStatusFlagLo) & ~rxStatusFlagHi) != 4'h0) |-> rdAck)
      else $error("double release dropped two sets");
   AST_RD_PULSE: assert property (rdReq |=> !rdReq)
      else $error("read request longer than one cycle");
   cover property (rxReleaseStrobe != 4'h0 && rxStatusFlagHi != 4'h0);
   cover property ((rxStatusFlagHi & rxStatusFlagLo & cfgDouble) != 4'h0);
   cover property (rxFlushStrobe != 4'h0);
endmodule

// File: test_usb_out_endpoint_buffer_ctrl.sv
// self-checking bench for the receive endpoint buffer link and its controller
`timescale 1ns/1ps
`include "oeb_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_usb_out_endpoint_buffer_ctrl
   import oeb_pkg::*;
;
   // ==========================================================================
   // stimulus signals
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rxByte;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, inBufReady, inNak, ovr;
   logic [3:0] ovrSeen = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, rxEp, txEp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic rxValid, rxPktEnd, rxShort, txDone, txAck;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   oeb_if bus ();
   // small set size keeps the continuous-mode runs short
   oeb_rx_dev #(.BUF_BYTES(8)) i_oeb_rx_dev (.clk_sys, .rst, .cpu(bus), .rxValid, .rxByte,
      .rxEp, .rxPktEnd, .rxShort, .txEp, .txDone, .txAck, .inBufReady, .inNak, .rxOverrun(ovr));
   oeb_cpu_ctrl i_oeb_cpu_ctrl (.clk_sys, .rst, .dev(bus), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   oeb_link_properties i_oeb_link_properties (.clk_sys, .rst, .cfgDouble(bus.cfgDouble),
      .rxReleaseStrobe(bus.rxReleaseStrobe), .rxFlushStrobe(bus.rxFlushStrobe),
      .rdReq(bus.rdReq), .rxStatusFlagHi(bus.rxStatusFlagHi),
      .rxStatusFlagLo(bus.rxStatusFlagLo), .rdAck(bus.rdAck));
   always #2.5 clk_sys = ~clk_sys;
   // overrun is a one-cycle pulse, so keep it until checked
   always @(posedge clk_sys) begin
      if (!rst) begin
         ovrSeen <= ovrSeen | ovr;
      end
   end
   // ==========================================================================
   // tasks
   task automatic stop_test();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge clk_sys);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge clk_sys);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // fifo data reaches the data register two edges after the write answer
   task automatic rdFifo();
      @(posedge clk_sys);
      axr(`OEB_REG_DATA);
   endtask
   task automatic chkSt(input logic [11:0] e);
      axr(`OEB_REG_STATUS);
      `CHK("status", e, rd[11:0])
   endtask
   // rxValid and rxPktEnd never share a cycle
   task automatic pkt(input logic [1:0] ep, input int n, input logic [7:0] b, input logic sh);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         rxValid <= 1'b1;
         rxEp <= ep;
         rxByte <= b + 8'(i);
      end
      @(posedge clk_sys);
      rxValid <= 1'b0;
      rxPktEnd <= 1'b1;
      rxShort <= sh;
      @(posedge clk_sys);
      rxPktEnd <= 1'b0;
      rxShort <= 1'b0;
   endtask
   task automatic tx(input logic [1:0] ep, input logic ack);
      @(posedge clk_sys);
      txEp <= ep;
      txDone <= 1'b1;
      txAck <= ack;
      @(posedge clk_sys);
      txDone <= 1'b0;
   endtask
   // ==========================================================================
   // sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      {rxValid, rxPktEnd, rxShort, txDone, txAck, rxByte, rxEp, txEp} = 17'h0;
      inBufReady = 4'h0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      axr(`OEB_REG_CFG);
      `CHK("cfg", 32'h0000_0000, rd)
      chkSt(12'h000);
      `CHK("nak", 4'hF, inNak)
      pkt(2'd0, 3, 8'h10, 1'b1);
      chkSt(12'h011);
      pkt(2'd0, 1, 8'h70, 1'b1);
      chkSt(12'h011);
      `CHK("overrun", 4'h1, ovrSeen)
      axw(`OEB_REG_RDREQ, 32'h0000_0001, 4'h1);
      rdFifo();
      `CHK("word", 32'h0001_1110, rd)
      axw(`OEB_REG_RDREQ, 32'h0000_0000, 4'h1);
      rdFifo();
      `CHK("byte", 32'h0001_0012, rd)
      axw(`OEB_REG_CMD, 32'h0000_0000, 4'h1);
      chkSt(12'h011);
      axw(`OEB_REG_CMD, 32'h0000_0001, 4'h1);
      chkSt(12'h000);
      axw(`OEB_REG_CFG, 32'h0000_0022, 4'h3);
      pkt(2'd1, 8, 8'h30, 1'b0);
      chkSt(12'h002);
      pkt(2'd1, 3, 8'h40, 1'b0);
      chkSt(12'h002);
      pkt(2'd1, 1, 8'h50, 1'b1);
      chkSt(12'h022);
      axw(`OEB_REG_CMD, 32'h0000_0002, 4'h1);
      chkSt(12'h002);
      axw(`OEB_REG_CMD, 32'h0000_0020, 4'h1);
      chkSt(12'h000);
      axw(`OEB_REG_CMD, 32'h0000_0020, 4'h1);
      chkSt(12'h000);
      axw(`OEB_REG_CFG, 32'h0000_0422, 4'h3);
      pkt(2'd2, 2, 8'h20, 1'b1);
      chkSt(12'h044);
      axw(`OEB_REG_RDREQ, 32'h0000_0005, 4'h1);
      chkSt(12'h000);
      axr(`OEB_REG_DATA);
      `CHK("auto word", 32'h0001_2120, rd)
      axw(`OEB_REG_CFG, 32'h0000_0C2A, 4'h3);
      pkt(2'd3, 1, 8'h60, 1'b1);
      pkt(2'd3, 1, 8'h61, 1'b1);
      chkSt(12'h088);
      axw(`OEB_REG_RDREQ, 32'h0000_0006, 4'h1);
      chkSt(12'h008);
      axw(`OEB_REG_RDREQ, 32'h0000_0006, 4'h1);
      chkSt(12'h000);
      tx(2'd0, 1'b1);
      tx(2'd0, 1'b0);
      axw(`OEB_REG_CFG, 32'h0000_2C2A, 4'h3);
      tx(2'd1, 1'b0);
      chkSt(12'h300);
      `CHK("nak", 4'hD, inNak)
      axw(`OEB_REG_CFG, 32'h0000_FFFF, 4'h2);
      axr(`OEB_REG_CFG);
      `CHK("cfg lane", 16'hFF2A, rd[15:0])
      axr(8'h14);
      `CHK("rd resp", `OEB_RESP_SLVERR, resp)
      axw(8'hFC, 32'h0000_0001, 4'hF);
      `CHK("wr resp", `OEB_RESP_SLVERR, resp)
      stop_test();
   end
endmodule
